// [rtl/cip_defs.svh]
// Register offsets, reset values, field positions and timing counts
// Assumes inclusion by bare name from design files only.
`ifndef CIP_DEFS_SVH
`define CIP_DEFS_SVH

// Slave address fields
`define CIP_GROUP_ID 4'hd
`define CIP_DEV_ADDR 3'h2

// Register offsets
`define CIP_OFS_CTRL 8'h00
`define CIP_OFS_CUR 8'h01
`define CIP_OFS_VOLT 8'h02
`define CIP_OFS_SPEC 8'h03
`define CIP_OFS_SAFE 8'h04
`define CIP_OFS_LED 8'h05
`define CIP_OFS_STA 8'h06
`define CIP_OFS_STB 8'h07
`define CIP_OFS_EVG 8'h08
`define CIP_OFS_EVC 8'h09
`define CIP_OFS_EVB 8'h0a
`define CIP_OFS_MSG 8'h0b
`define CIP_OFS_MSC 8'h0c
`define CIP_OFS_MSB 8'h0d
`define CIP_OFS_ID 8'h0e

// Reset values
`define CIP_RST_CTRL 8'h0a
`define CIP_RST_CUR 8'h01
`define CIP_RST_VOLT 8'h19
`define CIP_RST_SPEC 8'h8a
`define CIP_RST_SAFE 8'h40
`define CIP_RST_LED 8'h1f
`define CIP_RST_FLAG 8'h00
`define CIP_RST_MASK 8'h00

// Field positions
`define CIP_BIT_BOOST_FAULT 0

// Timing
`define CIP_MCLK_HZ 20000000
`define CIP_BOOST_S 32
`define CIP_BOOST_CYCLES (64'd`CIP_BOOST_S * 64'd`CIP_MCLK_HZ)

`endif

// [rtl/cip_pkg.sv]
// Types shared by the register port and its helpers
// Assumes nothing beyond a SystemVerilog compiler.
package cip_pkg;

	// Serial engine states
	typedef enum logic [2:0] {
		CIP_IDLE = 3'b000,
		CIP_ADDR = 3'b001,
		CIP_ADDR_ACK = 3'b010,
		CIP_SUB = 3'b011,
		CIP_SUB_ACK = 3'b100,
		CIP_WDATA = 3'b101,
		CIP_WDATA_ACK = 3'b110,
		CIP_RDATA = 3'b111
	} cip_state_e;

	// Status pin modes
	typedef enum logic [1:0] {
		CIP_STAT_AUTO = 2'b00,
		CIP_STAT_LOW = 2'b01,
		CIP_STAT_HIZ = 2'b10,
		CIP_STAT_UNDEF = 2'b11
	} cip_stat_e;

	// Charger modes
	typedef enum logic [1:0] {
		CIP_CHG_OFF = 2'b00,
		CIP_CHG_BOOST = 2'b01,
		CIP_CHG_CHARGE = 2'b10,
		CIP_CHG_RECHARGE = 2'b11
	} cip_chg_e;

	// Enable control register layout, bit 7 first
	typedef struct packed {
		logic [1:0] stat_mode;
		logic shunt_monitor_on;
		logic led_driver_on;
		logic linear_regulator_on;
		logic usb_line_detect_start;
		logic [1:0] charger_mode_select;
	} cip_ctrl_s;

endpackage : cip_pkg

// [rtl/cip_sync.sv]
// Three-stage input synchroniser with agreement filter
// Assumes inputs asynchronous to mclk.
`timescale 1ns/1ps

module cip_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level_out
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			// Shift chain; output follows once stages two and three agree
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					s1_reg <= RESET_VAL[i];
					s2_reg <= RESET_VAL[i];
					s3_reg <= RESET_VAL[i];
					level_out[i] <= RESET_VAL[i];
				end else begin
					s1_reg <= async_in[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						level_out[i] <= s3_reg;
					end
				end
			end
		end
	endgenerate

endmodule : cip_sync

// [rtl/cip_boost_timer.sv]
// Boost safety timer with restart and one-cycle expiry pulse
// Assumes run and restart come from mclk logic.
`timescale 1ns/1ps

module cip_boost_timer #(
	parameter logic [29:0] TIMEOUT_CYCLES = 30'd1000
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic restart,
	output logic expire
);

	logic [29:0] count_reg;

	// Counts only while boost runs; restart or idle clears it
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count_reg <= 30'h0;
			expire <= 1'b0;
		end else if (!run || restart) begin
			count_reg <= 30'h0;
			expire <= 1'b0;
		end else if (count_reg == TIMEOUT_CYCLES - 30'd1) begin
			count_reg <= 30'h0;
			expire <= 1'b1;
		end else begin
			count_reg <= count_reg + 30'd1;
			expire <= 1'b0;
		end
	end

endmodule : cip_boost_timer

// [rtl/cip_i2c_port.sv]
// Serial slave register port of the charger: bus engine and register bank
// Assumes an external pull-up on the data line and a bus controller
// that drives the serial clock.
//
// Contract
// R1: Accept bus rates up to 400 kbit/s
// R2: Upper address bits must equal 1101
// R3: Next three address bits must equal 010
// R4: Last address bit chooses read or write
// R5: Subaddress byte selects the register
// R6: Acknowledge match, then expect subaddress
// R7: Start is data falling with clock high
// R8: Stop is data rising with clock high
// R9: Data changes only while clock low
// R10: Acknowledge address, subaddress and data bytes
// R11: Stop ends the transaction
// R12: Register pointer advances after each data byte
// R13: Controller alone drives the serial clock
// R14: Data line driven open drain only
// R15: Status pin mode: follow, low, high impedance
// R16: Monitor and regulator bits switch functions
// R17: LED driver on by bit or pin
// R18: Detection bit self-clears when detection completes
// R19: Charger mode: off, boost, charge, recharge
// R20: Valid transaction restarts boost safety timer
// R21: Boost flag read or reset clears fault
// R22: Unmapped reads zero, writes ignored, still acknowledged
// R23: Empty write keeps subaddress for later read
`timescale 1ns/1ps
`include "cip_defs.svh"

module cip_i2c_port #(
	parameter logic [29:0] BOOST_TIMEOUT_CYCLES = 30'(`CIP_BOOST_CYCLES),
	parameter logic [7:0] PART_ID = 8'h5a // Arbitrary identity value
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	input wire logic led_ctrl_pin,
	input wire logic charging,
	input wire logic detect_done,
	input wire logic [7:0] state_a,
	input wire logic [7:0] state_b,
	input wire logic [7:0] set_general,
	input wire logic [7:0] set_charge,
	input wire logic [7:0] set_boost,
	output cip_pkg::cip_ctrl_s ctrl,
	output logic led_drive_on,
	output logic stat_pull_low,
	output logic [7:0] cfg_current,
	output logic [7:0] cfg_voltage,
	output logic [7:0] cfg_special,
	output logic [7:0] cfg_safety,
	output logic [7:0] cfg_led
);

	////////////////////////////////////////////////////////////////////
	// Pin conditioning and bus events

	logic scl_f;
	logic sda_f;
	logic led_pin_f;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;

	// Filtered bus pins; 20 MHz sampling leaves margin at 400 kHz, see R1
	cip_sync #(.W(2), .RESET_VAL(2'b11)) u_bus_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in({scl_i, sda_i}),
		.level_out({scl_f, sda_f})
	);

	// Filtered LED control pin
	cip_sync #(.W(1), .RESET_VAL(1'b0)) u_led_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in(led_ctrl_pin),
		.level_out(led_pin_f)
	);

	// Previous filtered levels
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_f;
			sda_d <= sda_f;
		end
	end

	// Edge and condition decode; clock is only sampled, see R13
	assign scl_rise = scl_f & ~scl_d;
	assign scl_fall = ~scl_f & scl_d;
	assign start_ev = scl_f & scl_d & sda_d & ~sda_f; // see R7
	assign stop_ev = scl_f & scl_d & ~sda_d & sda_f; // see R8

	////////////////////////////////////////////////////////////////////
	// Serial engine

	cip_pkg::cip_state_e state_reg;
	logic [3:0] cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic [7:0] ptr_reg;
	logic rw_reg;
	logic mack_reg;
	logic rack_reg;
	logic addr_match;
	logic byte_done;
	logic wr_en;
	logic rd_take;
	logic [7:0] rd_byte;
	logic boost_expire;
	cip_pkg::cip_ctrl_s ctrl_next;

	assign byte_done = scl_fall && (cnt_reg == 4'd8);
	assign addr_match = (state_reg == cip_pkg::CIP_ADDR) && byte_done &&
		(shift_reg[7:4] == `CIP_GROUP_ID) &&
		(shift_reg[3:1] == `CIP_DEV_ADDR); // see R2 see R3
	assign wr_en = (state_reg == cip_pkg::CIP_WDATA) && byte_done;
	assign rd_take = scl_fall && ((state_reg == cip_pkg::CIP_ADDR_ACK &&
		rw_reg) || (state_reg == cip_pkg::CIP_RDATA && rack_reg &&
		!mack_reg));

	// Bit capture on rising clock
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			shift_reg <= 8'h00;
			mack_reg <= 1'b1;
		end else if (scl_rise) begin
			if (rack_reg) begin
				mack_reg <= sda_f;
			end else begin
				shift_reg <= {shift_reg[6:0], sda_f};
			end
		end
	end

	// State, bit count and data drive; drive moves on falling clock
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= cip_pkg::CIP_IDLE;
			cnt_reg <= 4'h0;
			tx_reg <= 8'h00;
			rw_reg <= 1'b0;
			rack_reg <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (start_ev) begin
			state_reg <= cip_pkg::CIP_ADDR;
			cnt_reg <= 4'h0;
			rack_reg <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (stop_ev) begin
			state_reg <= cip_pkg::CIP_IDLE; // see R11
			rack_reg <= 1'b0;
			sda_oe_n <= 1'b1;
		end else begin
			if (scl_rise && state_reg != cip_pkg::CIP_RDATA) begin
				cnt_reg <= cnt_reg + 4'd1;
			end
			if (scl_fall) begin
				unique case (state_reg)
				cip_pkg::CIP_IDLE: begin
					sda_oe_n <= 1'b1;
				end
				cip_pkg::CIP_ADDR: begin
					if (addr_match) begin
						rw_reg <= shift_reg[0]; // see R4
						sda_oe_n <= 1'b0; // see R6 see R10
						state_reg <= cip_pkg::CIP_ADDR_ACK;
					end else if (byte_done) begin
						state_reg <= cip_pkg::CIP_IDLE;
					end
				end
				cip_pkg::CIP_ADDR_ACK: begin
					cnt_reg <= 4'h0;
					if (rw_reg) begin
						tx_reg <= {rd_byte[6:0], 1'b0};
						sda_oe_n <= rd_byte[7];
						cnt_reg <= 4'd1;
						state_reg <= cip_pkg::CIP_RDATA;
					end else begin
						sda_oe_n <= 1'b1;
						state_reg <= cip_pkg::CIP_SUB; // see R6
					end
				end
				cip_pkg::CIP_SUB: begin
					if (byte_done) begin
						sda_oe_n <= 1'b0; // see R10
						state_reg <= cip_pkg::CIP_SUB_ACK;
					end
				end
				cip_pkg::CIP_SUB_ACK, cip_pkg::CIP_WDATA_ACK: begin
					sda_oe_n <= 1'b1;
					cnt_reg <= 4'h0;
					state_reg <= cip_pkg::CIP_WDATA;
				end
				cip_pkg::CIP_WDATA: begin
					if (byte_done) begin
						sda_oe_n <= 1'b0; // see R10 see R22
						state_reg <= cip_pkg::CIP_WDATA_ACK;
					end
				end
				cip_pkg::CIP_RDATA: begin
					if (rack_reg) begin
						rack_reg <= 1'b0;
						if (!mack_reg) begin
							tx_reg <= {rd_byte[6:0], 1'b0};
							sda_oe_n <= rd_byte[7];
							cnt_reg <= 4'd1;
						end else begin
							state_reg <= cip_pkg::CIP_IDLE;
						end
					end else if (cnt_reg == 4'd8) begin
						sda_oe_n <= 1'b1; // Release for controller ack
						rack_reg <= 1'b1;
					end else begin
						sda_oe_n <= tx_reg[7];
						tx_reg <= {tx_reg[6:0], 1'b0};
						cnt_reg <= cnt_reg + 4'd1;
					end
				end
				endcase
			end
		end
	end

	// Open-drain: only the enable moves, the level stays low, see R14
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	// Register pointer: loaded by subaddress, advanced per data byte
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ptr_reg <= 8'h00;
		end else if (state_reg == cip_pkg::CIP_SUB && byte_done) begin
			ptr_reg <= shift_reg; // see R5 see R23
		end else if (wr_en || (state_reg == cip_pkg::CIP_RDATA &&
			scl_fall && !rack_reg && cnt_reg == 4'd8)) begin
			ptr_reg <= ptr_reg + 8'd1; // see R12
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register bank

	logic [7:0] cfg_reg [5];
	logic [7:0] flag_reg [3];
	logic [7:0] mask_reg [3];
	logic [7:0] flag_set [3];

	localparam logic [7:0] CFG_RST [5] = '{`CIP_RST_CUR, `CIP_RST_VOLT,
		`CIP_RST_SPEC, `CIP_RST_SAFE, `CIP_RST_LED};

	assign flag_set[0] = set_general;
	assign flag_set[1] = set_charge;
	assign flag_set[2] = set_boost |
		(8'(boost_expire) << `CIP_BIT_BOOST_FAULT);

	// Per-entry configuration, mask and flag registers
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_cfg
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					cfg_reg[gi] <= CFG_RST[gi];
				end else if (wr_en && ptr_reg == `CIP_OFS_CUR + 8'(gi)) begin
					cfg_reg[gi] <= shift_reg;
				end
			end
		end
		for (gi = 0; gi < 3; gi++) begin : g_evt
			// Masks are plain read/write storage
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					mask_reg[gi] <= `CIP_RST_MASK;
				end else if (wr_en && ptr_reg == `CIP_OFS_MSG + 8'(gi)) begin
					mask_reg[gi] <= shift_reg;
				end
			end
			// Sticky flags cleared by read; a new event wins, see R21
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					flag_reg[gi] <= `CIP_RST_FLAG;
				end else if (rd_take && ptr_reg == `CIP_OFS_EVG + 8'(gi)) begin
					flag_reg[gi] <= flag_set[gi];
				end else begin
					flag_reg[gi] <= flag_reg[gi] | flag_set[gi];
				end
			end
		end
	endgenerate

	assign cfg_current = cfg_reg[0];
	assign cfg_voltage = cfg_reg[1];
	assign cfg_special = cfg_reg[2];
	assign cfg_safety = cfg_reg[3];
	assign cfg_led = cfg_reg[4];

	// Enable control: writes load it, detection and timeout clear fields
	always_comb begin
		ctrl_next = ctrl;
		if (detect_done) begin
			ctrl_next.usb_line_detect_start = 1'b0; // see R18
		end
		if (boost_expire) begin
			ctrl_next.charger_mode_select = cip_pkg::CIP_CHG_OFF;
		end
		if (wr_en && ptr_reg == `CIP_OFS_CTRL) begin
			ctrl_next = shift_reg; // see R16 see R19
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl <= `CIP_RST_CTRL;
		end else begin
			ctrl <= ctrl_next;
		end
	end

	// Pin-facing enables derived from control
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			led_drive_on <= 1'b0;
			stat_pull_low <= 1'b0;
		end else begin
			led_drive_on <= ctrl.led_driver_on | led_pin_f; // see R17
			unique case (ctrl.stat_mode) // see R15
			cip_pkg::CIP_STAT_AUTO: stat_pull_low <= charging;
			cip_pkg::CIP_STAT_LOW: stat_pull_low <= 1'b1;
			cip_pkg::CIP_STAT_HIZ: stat_pull_low <= 1'b0;
			cip_pkg::CIP_STAT_UNDEF: stat_pull_low <= 1'b0;
			endcase
		end
	end

	// Read multiplexer; unmapped offsets read zero, see R22
	always_comb begin
		case (ptr_reg)
		`CIP_OFS_CTRL: rd_byte = ctrl;
		`CIP_OFS_CUR: rd_byte = cfg_reg[0];
		`CIP_OFS_VOLT: rd_byte = cfg_reg[1];
		`CIP_OFS_SPEC: rd_byte = cfg_reg[2];
		`CIP_OFS_SAFE: rd_byte = cfg_reg[3];
		`CIP_OFS_LED: rd_byte = cfg_reg[4];
		`CIP_OFS_STA: rd_byte = state_a;
		`CIP_OFS_STB: rd_byte = state_b;
		`CIP_OFS_EVG: rd_byte = flag_reg[0];
		`CIP_OFS_EVC: rd_byte = flag_reg[1];
		`CIP_OFS_EVB: rd_byte = flag_reg[2];
		`CIP_OFS_MSG: rd_byte = mask_reg[0];
		`CIP_OFS_MSC: rd_byte = mask_reg[1];
		`CIP_OFS_MSB: rd_byte = mask_reg[2];
		`CIP_OFS_ID: rd_byte = PART_ID;
		default: rd_byte = 8'h00;
		endcase
	end

	// Boost timer restarted by every addressed transaction, see R20
	cip_boost_timer #(.TIMEOUT_CYCLES(BOOST_TIMEOUT_CYCLES)) u_boost (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(ctrl.charger_mode_select == cip_pkg::CIP_CHG_BOOST),
		.restart(addr_match),
		.expire(boost_expire)
	);

	////////////////////////////////////////////////////////////////////
	// Checks

	addr_ack_a: assert property (@(posedge mclk) disable iff (!rst_n) // see R2
		addr_match && !start_ev && !stop_ev |=> !sda_oe_n)
		else $error("matched address not acknowledged");

	addr_miss_a: assert property (@(posedge mclk) disable iff (!rst_n) // see R3
		state_reg == cip_pkg::CIP_ADDR && byte_done && !addr_match &&
		!start_ev && !stop_ev |=> sda_oe_n && state_reg == cip_pkg::CIP_IDLE)
		else $error("foreign address answered");

	start_seen_a: assert property (@(posedge mclk) disable iff (!rst_n) // see R7
		start_ev |=> state_reg == cip_pkg::CIP_ADDR && cnt_reg == 4'h0)
		else $error("start not taken");

	stop_seen_a: assert property (@(posedge mclk) disable iff (!rst_n) // see R8
		stop_ev && !start_ev |=> state_reg == cip_pkg::CIP_IDLE && sda_oe_n)
		else $error("stop not taken");

	sda_timing_a: assert property (@(posedge mclk) disable iff (!rst_n) // see R9
		$changed(sda_oe_n) && !$past(start_ev) && !$past(stop_ev) |-> !scl_f)
		else $error("data moved while clock high");

	sub_load_a: assert property (@(posedge mclk) disable iff (!rst_n) // see R5
		state_reg == cip_pkg::CIP_SUB && byte_done && !start_ev && !stop_ev
		|=> ptr_reg == $past(shift_reg) ##1 !sda_oe_n)
		else $error("subaddress not loaded");

	ptr_step_a: assert property (@(posedge mclk) disable iff (!rst_n) // see R12
		wr_en && !start_ev && !stop_ev |=> ptr_reg == $past(ptr_reg) + 8'd1)
		else $error("pointer did not advance");

	unmapped_a: assert property (@(posedge mclk) disable iff (!rst_n) // see R22
		rd_take && ptr_reg > `CIP_OFS_ID |=> tx_reg == 8'h00 && !sda_oe_n)
		else $error("unmapped read not zero");

	detect_clr_a: assert property (@(posedge mclk) disable iff (!rst_n) // see R18
		detect_done && !(wr_en && ptr_reg == `CIP_OFS_CTRL)
		|=> !ctrl.usb_line_detect_start)
		else $error("detect bit not cleared");

	fault_clr_a: assert property (@(posedge mclk) disable iff (!rst_n) // see R21
		rd_take && ptr_reg == `CIP_OFS_EVB && !boost_expire &&
		!set_boost[`CIP_BIT_BOOST_FAULT] |=> !flag_reg[2][`CIP_BIT_BOOST_FAULT])
		else $error("boost fault not cleared");

	led_pin_a: assert property (@(posedge mclk) disable iff (!rst_n) // see R17
		led_pin_f |=> led_drive_on)
		else $error("pin did not enable LED");

	open_drain_a: assert property (@(posedge mclk) disable iff (!rst_n) // see R14
		!sda_oe_n |-> sda_o == 1'b0 && state_reg inside {
		cip_pkg::CIP_ADDR_ACK, cip_pkg::CIP_SUB_ACK,
		cip_pkg::CIP_WDATA_ACK, cip_pkg::CIP_RDATA})
		else $error("data line pulled outside a drive slot");

endmodule : cip_i2c_port

// [tb/cip_ctl_model.sv]
// Bus controller model: makes the serial clock, pulls the data wire low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps

module cip_ctl_model (
	input wire logic mclk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_pull_n
);
	// Idle bus: clock stands high outside frames
	initial begin
		scl = 1'b1;
		sda_pull_n = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(negedge mclk);
	endtask : hold

	// One bit; data moves only mid low phase
	task automatic bit_io(input logic b, output logic r);
		sda_pull_n = b;
		hold(4);
		scl = 1'b1;
		hold(7);
		r = sda_line;
		hold(1);
		scl = 1'b0;
		hold(4);
	endtask : bit_io

	// Start or repeated start
	task automatic start_c;
		sda_pull_n = 1'b1;
		hold(4);
		scl = 1'b1;
		hold(8);
		sda_pull_n = 1'b0;
		hold(8);
		scl = 1'b0;
		hold(4);
	endtask : start_c

	task automatic stop_c;
		sda_pull_n = 1'b0;
		hold(4);
		scl = 1'b1;
		hold(8);
		sda_pull_n = 1'b1;
		hold(8);
	endtask : stop_c

	// Byte out MSB first, then sample the acknowledge slot
	task automatic wbyte(input logic [7:0] d, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, ack_n);
	endtask : wbyte

	// Byte in, then acknowledge, or refuse when last
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask : rbyte
endmodule : cip_ctl_model

// [tb/tb_top.sv]
// Self-checking bench for the serial register port.
// Assumes the controller model and a pull-up on the data wire.
`timescale 1ns/1ps

module tb_top;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic scl, pull_n, sda_o, sda_oe_n, sda_line, led_on, stat_low;
	logic led_pin = 1'b0;
	logic charging = 1'b0;
	logic det_done = 1'b0;
	logic [7:0] st_a = 8'h6b;
	logic [7:0] st_b = 8'h94;
	logic [7:0] set_g = 8'h00;
	logic [7:0] set_c = 8'h00;
	logic [7:0] set_b = 8'h00;
	logic [7:0] cfg_cur, cfg_volt, cfg_spec, cfg_safe, cfg_led;
	logic [7:0] dat [16];
	cip_pkg::cip_ctrl_s ctrl;
	int mismatches = 0;
	int comparisons = 0;
	localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
	localparam logic [7:0] RST [16] = '{8'h0a, 8'h01, 8'h19, 8'h8a,
		8'h40, 8'h1f, 8'h6b, 8'h94, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, ID, 8'h00};
	localparam logic [7:0] BAD [3] = '{8'h54, 8'hd6, 8'hdc};

	always #25 mclk = ~mclk;

	// Open-drain data wire with pull-up
	assign sda_line = pull_n & (sda_oe_n ? 1'b1 : sda_o);

	cip_ctl_model cm (.mclk(mclk), .sda_line(sda_line), .scl(scl),
		.sda_pull_n(pull_n));

	cip_i2c_port #(.BOOST_TIMEOUT_CYCLES(30'd3000), .PART_ID(ID)) dut (
		.mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n), .led_ctrl_pin(led_pin),
		.charging(charging), .detect_done(det_done), .state_a(st_a),
		.state_b(st_b), .set_general(set_g), .set_charge(set_c),
		.set_boost(set_b), .ctrl(ctrl), .led_drive_on(led_on),
		.stat_pull_low(stat_low), .cfg_current(cfg_cur),
		.cfg_voltage(cfg_volt), .cfg_special(cfg_spec),
		.cfg_safety(cfg_safe), .cfg_led(cfg_led));

	task automatic wrap_up;
		if (mismatches == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Write transaction: address, subaddress, n bytes from dat
	task automatic wr(input logic [7:0] adr, input logic [7:0] sub,
		input int n);
		logic a;
		cm.start_c();
		cm.wbyte(adr, a);
		chk({7'h0, a}, {7'h0, adr[7:1] != 7'h6a}, "addr ack");
		if (adr[7:1] == 7'h6a) begin
			cm.wbyte(sub, a);
			chk({7'h0, a}, 8'h00, "sub ack");
			for (int i = 0; i < n; i++) begin
				cm.wbyte(dat[i], a);
				chk({7'h0, a}, 8'h00, "data ack");
			end
		end
		cm.stop_c();
	endtask : wr

	// Empty write sets the pointer, then a read of n bytes into dat
	task automatic rd(input logic [7:0] sub, input int n);
		logic a;
		wr(8'hd4, sub, 0);
		cm.start_c();
		cm.wbyte(8'hd5, a);
		chk({7'h0, a}, 8'h00, "read addr ack");
		for (int i = 0; i < n; i++)
			cm.rbyte(i == n - 1, dat[i]);
		cm.stop_c();
	endtask : rd

	// Watchdog against a hung run
	initial begin
		repeat (100000) @(negedge mclk);
		mismatches++;
		wrap_up();
	end

	// Main sequence
	initial begin
		logic [1:0] mm;
		repeat (8) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		chk(ctrl, 8'h0a, "ctrl reset");
		rd(8'h00, 16);
		foreach (RST[i])
			chk(dat[i], RST[i], "reset read");
		dat[0] = 8'hff;
		foreach (BAD[i])
			wr(BAD[i], 8'h00, 1);
		chk(ctrl, 8'h0a, "foreign address");
		for (int i = 0; i < 5; i++)
			dat[i] = 8'hc0 + 8'(i);
		wr(8'hd4, 8'h01, 5);
		chk(cfg_cur, 8'hc0, "cfg 1");
		chk(cfg_volt, 8'hc1, "cfg 2");
		chk(cfg_spec, 8'hc2, "cfg 3");
		chk(cfg_safe, 8'hc3, "cfg 4");
		chk(cfg_led, 8'hc4, "cfg 5");
		wr(8'hd4, 8'h0d, 3);
		rd(8'h0d, 3);
		chk(dat[0], 8'hc0, "mask");
		chk(dat[1], ID, "identity");
		chk(dat[2], 8'h00, "unmapped");
		// Status pin, enables, charger modes, pin-driven LED
		for (int m = 0; m < 4; m++) begin
			mm = 2'(m);
			charging = ~charging;
			led_pin = mm[1];
			dat[0] = {mm, ~mm[0], mm[0], mm[1], 1'b0, mm};
			wr(8'hd4, 8'h00, 1);
			chk(ctrl, dat[0], "ctrl write");
			chk({7'h0, stat_low},
				{7'h0, mm == 2'b01 || (mm == 2'b00 && charging)},
				"stat pin");
			chk({7'h0, led_on}, {7'h0, mm[0] | mm[1]}, "led");
		end
		led_pin = 1'b0;
		dat[0] = 8'h04;
		wr(8'hd4, 8'h00, 1);
		chk(ctrl, 8'h04, "detect set");
		det_done = 1'b1;
		@(negedge mclk);
		det_done = 1'b0;
		repeat (2) @(negedge mclk);
		chk(ctrl, 8'h00, "detect clear");
		set_g = 8'h11;
		set_c = 8'h40;
		set_b = 8'h82;
		@(negedge mclk);
		set_g = 8'h00;
		set_c = 8'h00;
		set_b = 8'h00;
		rd(8'h08, 3);
		chk(dat[0], 8'h11, "flags g");
		chk(dat[1], 8'h40, "flags c");
		chk(dat[2], 8'h82, "flags b");
		rd(8'h08, 3);
		chk(dat[0] | dat[1] | dat[2], 8'h00, "flags clear");
		// Boost timer held off by traffic, then left to expire
		dat[0] = 8'h01;
		wr(8'hd4, 8'h00, 1);
		for (int i = 0; i < 4; i++) begin
			repeat (1000) @(negedge mclk);
			rd(8'h07, 1);
		end
		chk(ctrl, 8'h01, "boost kept");
		repeat (3500) @(negedge mclk);
		chk(ctrl, 8'h00, "boost expired");
		rd(8'h0a, 1);
		chk(dat[0], 8'h01, "boost fault");
		rd(8'h0a, 1);
		chk(dat[0], 8'h00, "boost fault clear");
		wrap_up();
	end
endmodule : tb_top
